// file: rtl/ifcr_regs.sv
// Interrupt flag and control registers behind an APB slave
`timescale 1ns/1ps
`default_nettype none
module ifcr_regs
    import ifcr_pkg::*;
#(
    parameter bit LARGE_MEMORY = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] extPin,
    input wire ifcr_events_type events,
    input wire ifcr_core_type core,
    output logic [15:0] trapStatus,
    output logic [15:0] flagsFirst,
    output logic [15:0] flagsSecond,
    output logic [15:0] flagsThird,
    output logic alternateTableSelect,
    output logic [2:0] extEdgePolarity
);
    localparam logic [15:0] MASK_SECOND = LARGE_MEMORY ? MASK_SECOND_LARGE : MASK_SECOND_SMALL;

    logic [15:0] trap_ff;
    logic [15:0] edge_ff;
    logic [15:0] first_ff;
    logic [15:0] second_ff;
    logic [15:0] third_ff;
    logic delay_ff;
    logic [2:0] pinMeta_ff;
    logic [2:0] pinSync_ff;
    logic [2:0] pinPrev_ff;
    logic [31:0] nxt_prdata;
    logic [31:0] prdata_ff;
    logic [2:0] extHit;
    logic [15:0] setFirst;
    logic [15:0] setSecond;
    logic [15:0] setThird;
    logic [15:0] setTrap;
    logic wrEn;
    logic [15:0] wData;

    function automatic logic hitAddr(input logic [11:0] a, input logic [11:0] ref_a);
        hitAddr = (a == ref_a);
    endfunction : hitAddr

    // Software value merged with hardware sets, set dominates
    function automatic logic [15:0] mergeWrite(input logic [15:0] cur, input logic [15:0] wd,
            input logic [15:0] setv, input logic [15:0] mask, input logic we);
        logic [15:0] base;
        base = we ? wd : cur;
        mergeWrite = (base | setv) & mask;
    endfunction : mergeWrite

    assign wrEn = psel && penable && pwrite;
    assign wData = pwdata[15:0];
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Two-flop pin synchroniser, then edge history
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pinMeta_ff <= 3'h0;
            pinSync_ff <= 3'h0;
            pinPrev_ff <= 3'h0;
        end else begin
            pinMeta_ff <= extPin;
            pinSync_ff <= pinMeta_ff;
            pinPrev_ff <= pinSync_ff;
        end
    end

    // Edge detect with polarity select
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EXT; gi++) begin : gEdge
            always_comb begin
                if (edge_ff[gi]) begin
                    extHit[gi] = pinPrev_ff[gi] && !pinSync_ff[gi];
                end else begin
                    extHit[gi] = !pinPrev_ff[gi] && pinSync_ff[gi];
                end
            end
        end
    endgenerate

    // Event to bit placement in vector order
    always_comb begin
        setFirst = RESET_REG;
        setFirst[13] = events.adcDone;
        setFirst[12] = events.serialTx;
        setFirst[11] = events.serialRx;
        setFirst[10] = events.spiEvent;
        setFirst[9] = events.spiFault;
        setFirst[8] = events.timerThree;
        setFirst[7] = events.timerTwo;
        setFirst[6] = events.compareTwo;
        setFirst[5] = events.captureTwo;
        setFirst[3] = events.timerOne;
        setFirst[2] = events.compareOne;
        setFirst[1] = events.captureOne;
        setFirst[BIT_EXT0_REQ] = extHit[0];
        setSecond = RESET_REG;
        setSecond[BIT_EXT2_REQ] = extHit[2];
        setSecond[12] = events.timerFive;
        setSecond[11] = events.timerFour;
        setSecond[BIT_EXT1_REQ] = extHit[1];
        setSecond[3] = events.changeNotice;
        setSecond[2] = events.comparator;
        setSecond[1] = events.i2cMaster;
        setSecond[0] = events.i2cSlave;
        setThird = RESET_REG;
        setThird[5] = events.captureThree;
        setTrap = RESET_REG;
        setTrap[BIT_ADDRESS_FAULT] = core.addressFault;
        setTrap[BIT_STACK_FAULT] = core.stackFault;
        setTrap[BIT_CLOCK_LOSS] = core.clockLoss;
    end

    // Sticky request flags
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            first_ff <= RESET_REG;
            second_ff <= RESET_REG;
            third_ff <= RESET_REG;
        end else begin
            first_ff <= mergeWrite(first_ff, wData, setFirst, MASK_FIRST,
                wrEn && hitAddr(paddr, ADDR_REQUEST_FLAGS_FIRST));
            second_ff <= mergeWrite(second_ff, wData, setSecond, MASK_SECOND,
                wrEn && hitAddr(paddr, ADDR_REQUEST_FLAGS_SECOND));
            third_ff <= mergeWrite(third_ff, wData, setThird, MASK_THIRD,
                wrEn && hitAddr(paddr, ADDR_REQUEST_FLAGS_THIRD));
        end
    end

    // Trap status flags
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            trap_ff <= RESET_REG;
        end else begin
            trap_ff <= mergeWrite(trap_ff, wData, setTrap, MASK_TRAP,
                wrEn && hitAddr(paddr, ADDR_TRAP_CONTROL_STATUS));
        end
    end

    // Vector table and edge polarity control
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            edge_ff <= RESET_REG;
        end else if (wrEn && hitAddr(paddr, ADDR_VECTOR_EDGE_CONTROL)) begin
            edge_ff <= wData & MASK_EDGE_WRITE;
        end
    end

    // Delay-disable status follows the core
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            delay_ff <= 1'b0;
        end else begin
            delay_ff <= core.delayDisable;
        end
    end

    // Read mux
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            ADDR_TRAP_CONTROL_STATUS: nxt_prdata[15:0] = trap_ff;
            ADDR_VECTOR_EDGE_CONTROL: begin
                nxt_prdata[15:0] = edge_ff;
                nxt_prdata[BIT_DELAY_DISABLE] = delay_ff;
            end
            ADDR_REQUEST_FLAGS_FIRST: nxt_prdata[15:0] = first_ff;
            ADDR_REQUEST_FLAGS_SECOND: nxt_prdata[15:0] = second_ff;
            ADDR_REQUEST_FLAGS_THIRD: nxt_prdata[15:0] = third_ff;
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    // Read data registered at setup so it is valid in access phase
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;
    assign trapStatus = trap_ff;
    assign flagsFirst = first_ff;
    assign flagsSecond = second_ff;
    assign flagsThird = third_ff;
    assign alternateTableSelect = edge_ff[BIT_ALT_TABLE];
    assign extEdgePolarity = edge_ff[BIT_EXT2_EDGE:BIT_EXT0_EDGE];

    // Assertions
    sequence pinRise0_s;
        !pinPrev_ff[0] && pinSync_ff[0] && !edge_ff[0];
    endsequence

    sequence pinFall0_s;
        pinPrev_ff[0] && !pinSync_ff[0] && edge_ff[0];
    endsequence

    ext0_rise_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pinRise0_s |=> first_ff[0]) else $error("ext0 rise not flagged");
    ext0_fall_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pinFall0_s |=> first_ff[0]) else $error("ext0 fall not flagged");
    set_wins_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.adcDone |=> first_ff[13]) else $error("adc flag lost");
    flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        first_ff[2] && !(wrEn && paddr == ADDR_REQUEST_FLAGS_FIRST) |=> first_ff[2])
        else $error("flag dropped without write");
    trap_addr_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        core.addressFault |=> trapStatus[3]) else $error("address trap missing");
    trap_stack_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        core.stackFault |=> trapStatus[2]) else $error("stack trap missing");
    trap_clock_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        core.clockLoss |=> trapStatus[1]) else $error("clock trap missing");
    edge_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        edge_ff[13:3] == 11'h000) else $error("edge reserved bits set");
    third_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        third_ff[15:6] == 10'h000 && third_ff[4:0] == 5'h00)
        else $error("third reserved bits set");
    first_bit4_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        first_ff[4] == 1'b0 && first_ff[15:14] == 2'h0)
        else $error("first reserved bits set");
    alt_table_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrEn && paddr == ADDR_VECTOR_EDGE_CONTROL |=> alternateTableSelect == $past(pwdata[15]))
        else $error("alternate table not written");
    delay_status_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        core.delayDisable |=> delay_ff) else $error("delay status missing");
    delay_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !core.delayDisable |=> !delay_ff) else $error("delay status stuck");

    // Pin edge to flag for external 1 and 2
    sequence pinRise1_s;
        !pinPrev_ff[1] && pinSync_ff[1] && !edge_ff[1];
    endsequence

    sequence pinFall1_s;
        pinPrev_ff[1] && !pinSync_ff[1] && edge_ff[1];
    endsequence

    sequence pinRise2_s;
        !pinPrev_ff[2] && pinSync_ff[2] && !edge_ff[2];
    endsequence

    sequence pinFall2_s;
        pinPrev_ff[2] && !pinSync_ff[2] && edge_ff[2];
    endsequence

    ext1_rise_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pinRise1_s |=> flagsSecond[BIT_EXT1_REQ]) else $error("ext1 rise not flagged");
    ext1_fall_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pinFall1_s |=> flagsSecond[BIT_EXT1_REQ]) else $error("ext1 fall not flagged");
    ext2_rise_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pinRise2_s |=> flagsSecond[BIT_EXT2_REQ]) else $error("ext2 rise not flagged");
    ext2_fall_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pinFall2_s |=> flagsSecond[BIT_EXT2_REQ]) else $error("ext2 fall not flagged");

    // Synchroniser stages move one step per clock
    sync_meta_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        1'b1 |=> pinMeta_ff == $past(extPin)) else $error("pin meta stage wrong");
    sync_second_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        1'b1 |=> pinSync_ff == $past(pinMeta_ff)) else $error("pin sync stage wrong");

    // Each peripheral pulse lands on its own flag bit, timer four and five only with LARGE_MEMORY set
    serial_tx_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.serialTx |=> flagsFirst[12]) else $error("serial tx flag lost");
    serial_rx_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.serialRx |=> flagsFirst[11]) else $error("serial rx flag lost");
    spi_event_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.spiEvent |=> flagsFirst[10]) else $error("spi event flag lost");
    spi_fault_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.spiFault |=> flagsFirst[9]) else $error("spi fault flag lost");
    timer_three_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.timerThree |=> flagsFirst[8]) else $error("timer three flag lost");
    timer_two_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.timerTwo |=> flagsFirst[7]) else $error("timer two flag lost");
    compare_two_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.compareTwo |=> flagsFirst[6]) else $error("compare two flag lost");
    capture_two_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.captureTwo |=> flagsFirst[5]) else $error("capture two flag lost");
    timer_one_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.timerOne |=> flagsFirst[3]) else $error("timer one flag lost");
    compare_one_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.compareOne |=> flagsFirst[2]) else $error("compare one flag lost");
    capture_one_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.captureOne |=> flagsFirst[1]) else $error("capture one flag lost");
    timer_five_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.timerFive && LARGE_MEMORY |=> flagsSecond[12]) else $error("timer five lost");
    timer_four_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.timerFour && LARGE_MEMORY |=> flagsSecond[11]) else $error("timer four lost");
    change_notice_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.changeNotice |=> flagsSecond[3]) else $error("change flag lost");
    comparator_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.comparator |=> flagsSecond[2]) else $error("comparator flag lost");
    i2c_master_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.i2cMaster |=> flagsSecond[1]) else $error("i2c master flag lost");
    i2c_slave_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.i2cSlave |=> flagsSecond[0]) else $error("i2c slave flag lost");
    capture_three_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        events.captureThree |=> flagsThird[5]) else $error("capture three flag lost");

    // Unimplemented bits never show up
    second_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (second_ff & ~MASK_SECOND) == RESET_REG) else $error("second reserved bits set");
    trap_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (trap_ff & ~MASK_TRAP) == RESET_REG) else $error("trap reserved bits set");

    // Plain writes land when no hardware set competes
    first_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrEn && paddr == ADDR_REQUEST_FLAGS_FIRST && setFirst == RESET_REG
        |=> first_ff == ($past(wData) & MASK_FIRST)) else $error("first write lost");
    third_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrEn && paddr == ADDR_REQUEST_FLAGS_THIRD && setThird == RESET_REG
        |=> third_ff == ($past(wData) & MASK_THIRD)) else $error("third write lost");
    trap_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrEn && paddr == ADDR_TRAP_CONTROL_STATUS && setTrap == RESET_REG
        |=> trapStatus == ($past(wData) & MASK_TRAP)) else $error("trap write lost");

    // Control bits change only by a write
    edge_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrEn && paddr == ADDR_VECTOR_EDGE_CONTROL |=> extEdgePolarity == $past(pwdata[2:0]))
        else $error("edge polarity not written");
    edge_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(wrEn && paddr == ADDR_VECTOR_EDGE_CONTROL) |=> $stable(edge_ff))
        else $error("edge control changed without write");

    // Read data captured in setup, upper half zero
    read_capture_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        psel && !penable |=> prdata == $past(nxt_prdata)) else $error("read data not captured");
    read_upper_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        prdata[31:16] == 16'h0000) else $error("read upper half set");
    read_delay_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        psel && !penable && paddr == ADDR_VECTOR_EDGE_CONTROL
        |=> prdata[BIT_DELAY_DISABLE] == $past(delay_ff)) else $error("delay bit not read");
    bus_ok_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pready && !pslverr) else $error("bus answer wrong");

    // No flag falls without a write to its register
    generate
        for (gi = 0; gi < 16; gi++) begin : gSticky
            first_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
                first_ff[gi] && !(wrEn && paddr == ADDR_REQUEST_FLAGS_FIRST) |=> first_ff[gi])
                else $error("first flag dropped");
            second_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
                second_ff[gi] && !(wrEn && paddr == ADDR_REQUEST_FLAGS_SECOND)
                |=> second_ff[gi]) else $error("second flag dropped");
            third_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
                third_ff[gi] && !(wrEn && paddr == ADDR_REQUEST_FLAGS_THIRD) |=> third_ff[gi])
                else $error("third flag dropped");
        end
    endgenerate
endmodule : ifcr_regs
`default_nettype wire

// file: rtl/ifcr_pkg.sv
// Package for the interrupt flag and control register slice
package ifcr_pkg;
    // Register byte offsets on APB
    localparam logic [11:0] ADDR_TRAP_CONTROL_STATUS = 12'h000;
    localparam logic [11:0] ADDR_VECTOR_EDGE_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_REQUEST_FLAGS_FIRST = 12'h008;
    localparam logic [11:0] ADDR_REQUEST_FLAGS_SECOND = 12'h00c;
    localparam logic [11:0] ADDR_REQUEST_FLAGS_THIRD = 12'h010;
    // Trap status positions
    localparam int BIT_ADDRESS_FAULT = 3;
    localparam int BIT_STACK_FAULT = 2;
    localparam int BIT_CLOCK_LOSS = 1;
    // Vector and edge control positions
    localparam int BIT_ALT_TABLE = 15;
    localparam int BIT_DELAY_DISABLE = 14;
    localparam int BIT_EXT2_EDGE = 2;
    localparam int BIT_EXT1_EDGE = 1;
    localparam int BIT_EXT0_EDGE = 0;
    // Implemented bits per register
    localparam logic [15:0] MASK_TRAP = 16'h000e;
    localparam logic [15:0] MASK_EDGE_WRITE = 16'h8007;
    localparam logic [15:0] MASK_FIRST = 16'h3fef;
    localparam logic [15:0] MASK_SECOND_LARGE = 16'h381f;
    localparam logic [15:0] MASK_SECOND_SMALL = 16'h201f;
    localparam logic [15:0] MASK_THIRD = 16'h0020;
    localparam logic [15:0] RESET_REG = 16'h0000;
    // External interrupt positions in the flag registers
    localparam int BIT_EXT0_REQ = 0;
    localparam int BIT_EXT1_REQ = 4;
    localparam int BIT_EXT2_REQ = 13;
    localparam int NUM_EXT = 3;

    // Peripheral request pulses, one cycle each
    typedef struct packed {
        logic adcDone;
        logic serialTx;
        logic serialRx;
        logic spiEvent;
        logic spiFault;
        logic timerThree;
        logic timerTwo;
        logic compareTwo;
        logic captureTwo;
        logic timerOne;
        logic compareOne;
        logic captureOne;
        logic timerFive;
        logic timerFour;
        logic changeNotice;
        logic comparator;
        logic i2cMaster;
        logic i2cSlave;
        logic captureThree;
    } ifcr_events_type;

    // Trap event pulses and core status level
    typedef struct packed {
        logic addressFault;
        logic stackFault;
        logic clockLoss;
        logic delayDisable;
    } ifcr_core_type;
endpackage : ifcr_pkg

// file: tb/ifcr_source_model.sv
// Peripheral and core event source model for the flag register bench
`timescale 1ns/1ps
`default_nettype none
module ifcr_source_model
    import ifcr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic fire,
    input wire logic [18:0] pattern,
    input wire logic [3:0] coreReq,
    output var ifcr_events_type events,
    output var ifcr_core_type core
);
    // One-cycle request pulses, trap pulses and delay-disable level
    always_ff @(posedge clk_sys) begin
        events <= fire ? ifcr_events_type'(pattern) : '0;
        core <= ifcr_core_type'(coreReq);
    end
endmodule : ifcr_source_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the interrupt flag and control registers
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ifcr_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset_n, psel, penable, pwrite, fire, pready, pslverr, altSel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] extPin, extPol;
    logic [18:0] pattern;
    logic [3:0] coreReq;
    logic [15:0] trapS, flags1, flags2, flags3;
    logic [15:0] expReg [5];
    ifcr_events_type events;
    ifcr_core_type core;
    int nErrors = 0, nCompared = 0, cycles = 0;
    logic [31:0] seed = 32'h0000004c;
    logic dd = 1'b0;
    localparam logic [15:0] MASK [5] = '{MASK_TRAP, MASK_EDGE_WRITE, MASK_FIRST,
        MASK_SECOND_LARGE, MASK_THIRD};
    // Register index times 16 plus bit, per event bit
    localparam int DST [19] = '{69, 48, 49, 50, 51, 59, 60, 33, 34, 35, 37, 38, 39, 40, 41,
        42, 43, 44, 45};
    ifcr_regs #(.LARGE_MEMORY(1'b1)) i_ifcr_regs (.clk_sys(clk_sys), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .extPin(extPin),
        .events(events), .core(core), .trapStatus(trapS), .flagsFirst(flags1),
        .flagsSecond(flags2), .flagsThird(flags3), .alternateTableSelect(altSel),
        .extEdgePolarity(extPol));
    ifcr_source_model i_ifcr_source_model (.clk_sys(clk_sys), .fire(fire),
        .pattern(pattern), .coreReq(coreReq), .events(events), .core(core));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nErrors++;
            end_sim();
        end
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    task automatic end_sim();
        if (nErrors == 0 && nCompared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nErrors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer
    task automatic wr(input int i, input logic [15:0] v);
        apb_xfer(1'b1, 12'(i * 4), {16'h0000, v});
        expReg[i] = v & MASK[i];
    endtask : wr
    task automatic rd_chk(input int i);
        logic [15:0] e, p;
        e = expReg[i] | ((i == 1 && dd) ? 16'h4000 : 16'h0000);
        apb_xfer(1'b0, 12'(i * 4), 32'h0);
        p = (i == 0) ? trapS : (i == 2) ? flags1 : (i == 3) ? flags2 : flags3;
        p = (i == 1) ? {altSel, e[14:3], extPol} : p;
        check(rd, {16'h0000, e});
        check({16'h0000, p}, {16'h0000, e});
        check({31'h0, pslverr}, 32'h0);
    endtask : rd_chk
    task automatic pulse(input logic [18:0] p, input logic [2:0] tr);
        @(posedge clk_sys);
        fire <= 1'b1;
        pattern <= p;
        coreReq <= {tr, dd};
        @(posedge clk_sys);
        fire <= 1'b0;
        coreReq <= {3'b000, dd};
        repeat (3) @(posedge clk_sys);
        for (int b = 0; b < 19; b++) begin
            if (p[b]) expReg[DST[b] / 16][DST[b] % 16] = 1'b1;
        end
        expReg[0][3:1] = expReg[0][3:1] | tr;
    endtask : pulse
    initial begin
        {reset_n, psel, penable, pwrite, fire} = 5'h00;
        {paddr, pwdata, extPin, pattern, coreReq} = '0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            expReg[i] = RESET_REG;
            rd_chk(i);
        end
        apb_xfer(1'b1, 12'hffc, 32'hffffffff);
        apb_xfer(1'b0, 12'hffc, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(i, 16'hffff);
            rd_chk(i);
            wr(i, 16'h0000);
        end
        repeat (8) begin
            seed = xorshift(seed);
            pulse(seed[18:0], seed[21:19]);
            for (int i = 0; i < 5; i++) begin
                rd_chk(i);
                if (i != 1) wr(i, expReg[i] & seed[31:16]);
            end
        end
        dd = 1'b1;
        pulse(19'h0, 3'b000);
        wr(1, 16'h0000);
        rd_chk(1);
        dd = 1'b0;
        pulse(19'h0, 3'b000);
        wr(1, 16'hc000);
        rd_chk(1);
        for (int k = 0; k < 6; k++) begin
            wr(1, k[0] ? 16'h0007 : 16'h0000);
            extPin <= {3{k[0]}};
            repeat (8) @(posedge clk_sys);
            wr(2, 16'h0000);
            wr(3, 16'h0000);
            extPin[k / 2] <= ~k[0];
            repeat (8) @(posedge clk_sys);
            if (k / 2 == 0) expReg[2][BIT_EXT0_REQ] = 1'b1;
            else expReg[3][(k / 2 == 1) ? BIT_EXT1_REQ : BIT_EXT2_REQ] = 1'b1;
            rd_chk(2);
            rd_chk(3);
            wr(2, 16'h0000);
            wr(3, 16'h0000);
            extPin[k / 2] <= k[0];
            repeat (8) @(posedge clk_sys);
            rd_chk(2);
            rd_chk(3);
        end
        fork
            wr(2, 16'h0000);
            pulse(19'h40000, 3'b000);
        join
        rd_chk(2);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
